/* logic/acd_pkg.sv */
// shared constants and helpers of the serial command decoder, both ends
// How it works
// - averaging allowed in all scan modes
// - scan mode 10 repeats one channel
// - clock mode 11 suppresses averaging
// - single-channel scan count gives 4/8/12/16
// - 0001xxxx arms a following 16-bit word
// - 00001xxx writes reset control bits
// - either bit2 value clears FIFO; bit2 one also resets
// - defaults zero, setup clock mode and reference 10
// - slow bit delays output, clears FIFO
// - force bias: always on, no wake delay in clock modes 01 and 11
// - 000000xx selects GPIO configure/write/read
// - configure byte applied at chip-select rise
// - all GPIO pins inputs after power-up
// - write byte applied at chip-select rise
// - read shifts pin states out next byte
// - pin mode from configure and write bits
// - 16-bit word MSB first, falling-edge sampling
// - early chip-select rise discards the transfer
// - code 1111 nibble 0100 tri-states flagged outputs
package acd_pkg;
    localparam int         SYS_CLK_PERIOD_NS = 100;
    localparam int         SLOW_DELAY_NS     = 15;
    localparam int         SLOW_DELAY_CYC    =
        (SLOW_DELAY_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int         HOST_SCLK_HALF_NS = 800;
    localparam int         HOST_HALF_CYC     = HOST_SCLK_HALF_NS / SYS_CLK_PERIOD_NS;

    localparam logic [4:0] CMD_LAST      = 5'h07;
    localparam logic [4:0] DATA_LAST     = 5'h07;
    localparam logic [4:0] DAC_LAST      = 5'h0f;
    localparam logic [6:0] SYNC_RST      = 7'h01;

    localparam logic [5:0] GPIO_PREFIX   = 6'h00;
    localparam logic [4:0] RESET_PREFIX  = 5'h01;
    localparam logic [3:0] DAC_SEL_NIB   = 4'h1;
    localparam logic [2:0] AVG_PREFIX    = 3'h1;
    localparam logic [1:0] SETUP_PREFIX  = 2'h1;
    localparam logic       CONV_PREFIX   = 1'b1;

    localparam int         RST_FULL_BIT  = 2;
    localparam int         RST_SLOW_BIT  = 1;
    localparam int         RST_FBG_BIT   = 0;
    localparam int         AVG_EN_BIT    = 4;
    localparam int         SETUP_CLK_LSB = 4;
    localparam int         SETUP_REF_LSB = 2;
    localparam int         CONV_SCAN_LSB = 1;

    localparam logic [4:0] AVG_RST       = 5'h00;
    localparam logic [1:0] CLK_MODE_RST  = 2'h2;
    localparam logic [1:0] REF_SEL_RST   = 2'h2;
    localparam logic [1:0] SCAN_RST      = 2'h0;
    localparam logic [3:0] GPIO_CFG_RST  = 4'h0;
    localparam logic [3:0] GPIO_WR_RST   = 4'hf;

    localparam logic [1:0] SCAN_SINGLE   = 2'h2;
    localparam logic [1:0] CLK_NO_AVG    = 2'h3;
    localparam logic [1:0] CLK_WAKE      = 2'h1;
    localparam logic [5:0] ONE_CONV      = 6'h01;
    localparam logic [4:0] ONE_RESULT    = 5'h01;

    localparam logic [3:0] DAC_CTRL_CFG  = 4'hf;
    localparam logic [3:0] DAC_HIZ_NIB   = 4'h4;
    localparam logic [2:0] DAC_PWRUP_NIB = 3'h1;

    localparam logic [1:0] HOST_REG_DATA = 2'h0;
    localparam logic [1:0] HOST_REG_CTRL = 2'h1;
    localparam logic [1:0] HOST_REG_STAT = 2'h2;
    localparam logic [1:0] HOST_REG_RX   = 2'h3;
    localparam logic [4:0] HOST_MAX_BITS = 5'h18;

    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_RD   = 2'b01,
        OP_WR   = 2'b10,
        OP_CFG  = 2'b11
    } acd_gpio_op_t;

    function automatic logic [5:0] avg_conversions(input logic [1:0] sel);
        avg_conversions = 6'h04 << sel;
    endfunction

    function automatic logic [4:0] scan_results(input logic [1:0] sel);
        scan_results = {1'b0, sel, 2'b00} + 5'h04;
    endfunction
endpackage

/* logic/acd_link_if.sv */
// serial link between host and converter: chip select, clock, data each way
`timescale 1ns/1ns
`default_nettype none
interface acd_link_if;
    logic cs_n;
    logic sclk;
    logic din;
    logic dout;
    modport dev  (input cs_n, input sclk, input din, output dout);
    modport host (output cs_n, output sclk, output din, input dout);
endinterface
`default_nettype wire

/* logic/acd_device.sv */
// converter end: command decode, reset control, GPIO and DAC word handling
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module acd_device
    import acd_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_resetn,
    acd_link_if.dev          link,
    input  wire logic [3:0]  i_gpio_in,
    output logic      [3:0]  o_gpio_out,
    output logic      [3:0]  o_gpio_oe,
    output logic             o_avg_active,
    output logic      [5:0]  o_avg_conversions,
    output logic             o_single_channel_repeat,
    output logic      [4:0]  o_scan_results,
    output logic      [1:0]  o_scan_mode,
    output logic      [1:0]  o_clock_mode,
    output logic      [1:0]  o_ref_sel,
    output logic             o_fifo_clear,
    output logic             o_slow_mode,
    output logic             o_bias_force,
    output logic             o_wake_delay_bypass,
    output logic             o_dac_word_valid,
    output logic      [3:0]  o_dac_ctrl,
    output logic      [11:0] o_dac_data,
    output logic      [3:0]  o_dac_hiz
);
    typedef enum logic [1:0] {
        ST_CMD  = 2'b00,
        ST_DATA = 2'b01,
        ST_DAC  = 2'b10,
        ST_SKIP = 2'b11
    } acd_dev_state_t;

    logic [6:0]     s1_reg, s2_reg, s3_reg, filt_reg, prev_reg;
    acd_dev_state_t state_reg;
    logic [4:0]     cnt_reg;
    logic [15:0]    shift_reg;
    acd_gpio_op_t   op_reg;
    logic           armed_reg;
    logic           pend_valid_reg, pend_cfg_reg;
    logic [3:0]     pend_data_reg, gpio_cfg_reg, gpio_wr_reg;
    logic [3:0]     gpio_out_reg, gpio_oe_reg;
    logic [4:0]     avg_reg;
    logic [1:0]     clk_mode_reg, ref_sel_reg, scan_reg;
    logic           slow_reg, fbg_reg, fifo_clr_reg;
    logic           avg_act_reg, single_reg, wake_byp_reg;
    logic [5:0]     avg_conv_reg;
    logic [4:0]     scan_res_reg;
    logic           dac_valid_reg;
    logic [3:0]     dac_ctrl_reg, dac_hiz_reg;
    logic [11:0]    dac_data_reg;
    logic [7:0]     out_sr_reg;
    logic [SLOW_DELAY_CYC-1:0] dly_reg;
    logic           dout_reg;

    logic           cs_fall, cs_rise, sclk_fall, din;
    logic [3:0]     pins;
    logic [7:0]     byte_val;
    logic [15:0]    word_val;
    logic           cmd_done, data_done, dac_done;
    logic           dec_reset, dec_dac_sel, dec_avg, dec_setup, dec_conv;
    acd_gpio_op_t   dec_op;

    // a bit change is taken only once the second and third stages agree
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s1_reg   <= SYNC_RST;
            s2_reg   <= SYNC_RST;
            s3_reg   <= SYNC_RST;
            filt_reg <= SYNC_RST;
            prev_reg <= SYNC_RST;
        end else begin
            s1_reg   <= {i_gpio_in, link.din, link.sclk, link.cs_n};
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            filt_reg <= (s3_reg & ~(s2_reg ^ s3_reg)) | (filt_reg & (s2_reg ^ s3_reg));
            prev_reg <= filt_reg;
        end
    end

    always_comb begin
        cs_fall     = prev_reg[0] & ~filt_reg[0];
        cs_rise     = ~prev_reg[0] & filt_reg[0];
        sclk_fall   = prev_reg[1] & ~filt_reg[1] & ~filt_reg[0];
        din         = filt_reg[2];
        pins        = filt_reg[6:3];
        byte_val    = {shift_reg[6:0], din};
        word_val    = {shift_reg[14:0], din};
        cmd_done    = sclk_fall && (state_reg == ST_CMD) && (cnt_reg == CMD_LAST);
        data_done   = sclk_fall && (state_reg == ST_DATA) && (cnt_reg == DATA_LAST);
        dac_done    = sclk_fall && (state_reg == ST_DAC) && (cnt_reg == DAC_LAST);
        dec_op      = (byte_val[7:2] == GPIO_PREFIX) ? acd_gpio_op_t'(byte_val[1:0])
                                                     : OP_NONE;
        dec_reset   = (byte_val[7:3] == RESET_PREFIX);
        dec_dac_sel = (byte_val[7:4] == DAC_SEL_NIB);
        dec_avg     = (byte_val[7:5] == AVG_PREFIX);
        dec_setup   = (byte_val[7:6] == SETUP_PREFIX);
        dec_conv    = (byte_val[7] == CONV_PREFIX);
    end

    // frame sequencing; a chip-select edge always restarts the bit count
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= ST_CMD;
            cnt_reg   <= 5'h00;
            shift_reg <= 16'h0000;
            op_reg    <= OP_NONE;
        end else if (cs_fall) begin
            state_reg <= armed_reg ? ST_DAC : ST_CMD;
            cnt_reg   <= 5'h00;
        end else if (cs_rise) begin
            state_reg <= ST_CMD;
            cnt_reg   <= 5'h00;
        end else if (sclk_fall) begin
            shift_reg <= word_val;
            if (cmd_done) begin
                cnt_reg <= 5'h00;
                op_reg  <= dec_op;
                if (dec_op != OP_NONE) begin
                    state_reg <= ST_DATA;
                end else if (dec_dac_sel) begin
                    state_reg <= ST_DAC;
                end else begin
                    state_reg <= ST_CMD;
                end
            end else if (data_done) begin
                state_reg <= ST_SKIP;
            end else if (dac_done) begin
                state_reg <= ST_CMD;
                cnt_reg   <= 5'h00;
            end else if (state_reg != ST_SKIP) begin
                cnt_reg <= cnt_reg + 5'h01;
            end
        end
    end

    // an armed word survives a cut frame and is retried in the next one
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            armed_reg <= 1'b0;
        end else if (cmd_done && dec_dac_sel) begin
            armed_reg <= 1'b1;
        end else if (dac_done) begin
            armed_reg <= 1'b0;
        end
    end

    // pending byte only exists once all eight bits arrived
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pend_valid_reg <= 1'b0;
            pend_cfg_reg   <= 1'b0;
            pend_data_reg  <= 4'h0;
            gpio_cfg_reg   <= GPIO_CFG_RST;
            gpio_wr_reg    <= GPIO_WR_RST;
        end else if (data_done && (op_reg != OP_RD)) begin
            pend_valid_reg <= 1'b1;
            pend_cfg_reg   <= (op_reg == OP_CFG);
            pend_data_reg  <= byte_val[7:4];
        end else if (cs_rise) begin
            pend_valid_reg <= 1'b0;
            if (pend_valid_reg && pend_cfg_reg) begin
                gpio_cfg_reg <= pend_data_reg;
            end else if (pend_valid_reg) begin
                gpio_wr_reg <= pend_data_reg;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            gpio_out_reg <= 4'h0;
            gpio_oe_reg  <= 4'h0;
        end else begin
            gpio_out_reg <= gpio_cfg_reg & gpio_wr_reg;
            gpio_oe_reg  <= gpio_cfg_reg | ~gpio_wr_reg;
        end
    end

    // the DAC and GPIO state lives elsewhere, so a full reset leaves it alone
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            avg_reg      <= AVG_RST;
            clk_mode_reg <= CLK_MODE_RST;
            ref_sel_reg  <= REF_SEL_RST;
            scan_reg     <= SCAN_RST;
            slow_reg     <= 1'b0;
            fbg_reg      <= 1'b0;
            fifo_clr_reg <= 1'b0;
        end else begin
            fifo_clr_reg <= cmd_done && dec_reset;
            if (cmd_done && dec_reset) begin
                slow_reg <= byte_val[RST_SLOW_BIT];
                fbg_reg  <= byte_val[RST_FBG_BIT];
                if (byte_val[RST_FULL_BIT]) begin
                    avg_reg      <= AVG_RST;
                    clk_mode_reg <= CLK_MODE_RST;
                    ref_sel_reg  <= REF_SEL_RST;
                    scan_reg     <= SCAN_RST;
                end
            end else if (cmd_done && dec_avg) begin
                avg_reg <= byte_val[AVG_EN_BIT:0];
            end else if (cmd_done && dec_setup) begin
                clk_mode_reg <= byte_val[SETUP_CLK_LSB+1:SETUP_CLK_LSB];
                ref_sel_reg  <= byte_val[SETUP_REF_LSB+1:SETUP_REF_LSB];
            end else if (cmd_done && dec_conv) begin
                scan_reg <= byte_val[CONV_SCAN_LSB+1:CONV_SCAN_LSB];
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            avg_act_reg  <= 1'b0;
            avg_conv_reg <= ONE_CONV;
            single_reg   <= 1'b0;
            scan_res_reg <= ONE_RESULT;
            wake_byp_reg <= 1'b0;
        end else begin
            avg_act_reg  <= avg_reg[AVG_EN_BIT] && (clk_mode_reg != CLK_NO_AVG);
            avg_conv_reg <= (avg_reg[AVG_EN_BIT] && (clk_mode_reg != CLK_NO_AVG))
                            ? avg_conversions(avg_reg[3:2]) : ONE_CONV;
            single_reg   <= (scan_reg == SCAN_SINGLE);
            scan_res_reg <= (scan_reg == SCAN_SINGLE) ? scan_results(avg_reg[1:0])
                                                      : ONE_RESULT;
            wake_byp_reg <= fbg_reg && ((clk_mode_reg == CLK_WAKE)
                            || (clk_mode_reg == CLK_NO_AVG));
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            dac_valid_reg <= 1'b0;
            dac_ctrl_reg  <= 4'h0;
            dac_data_reg  <= 12'h000;
            dac_hiz_reg   <= 4'h0;
        end else begin
            dac_valid_reg <= dac_done;
            if (dac_done) begin
                dac_ctrl_reg <= word_val[15:12];
                dac_data_reg <= word_val[11:0];
                if (word_val[15:12] == DAC_CTRL_CFG && word_val[3:0] == DAC_HIZ_NIB) begin
                    dac_hiz_reg <= dac_hiz_reg | word_val[7:4];
                end else if (word_val[15:12] == DAC_CTRL_CFG
                             && word_val[3:1] == DAC_PWRUP_NIB) begin
                    dac_hiz_reg <= dac_hiz_reg & ~word_val[7:4];
                end
            end
        end
    end

    // slow mode trades a little throughput for hold margin on the host
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            out_sr_reg <= 8'h00;
            dly_reg    <= '0;
            dout_reg   <= 1'b0;
        end else begin
            if (cs_fall || cs_rise) begin
                out_sr_reg <= 8'h00;
            end else if (cmd_done && dec_op == OP_RD) begin
                out_sr_reg <= {4'h0, pins};
            end else if (sclk_fall) begin
                out_sr_reg <= {out_sr_reg[6:0], 1'b0};
            end
            dly_reg[0] <= out_sr_reg[7];
            for (int i = 1; i < SLOW_DELAY_CYC; i++) begin
                dly_reg[i] <= dly_reg[i-1];
            end
            dout_reg <= slow_reg ? dly_reg[SLOW_DELAY_CYC-1] : out_sr_reg[7];
        end
    end

    assign link.dout               = dout_reg;
    assign o_gpio_out              = gpio_out_reg;
    assign o_gpio_oe               = gpio_oe_reg;
    assign o_avg_active            = avg_act_reg;
    assign o_avg_conversions       = avg_conv_reg;
    assign o_single_channel_repeat = single_reg;
    assign o_scan_results          = scan_res_reg;
    assign o_scan_mode             = scan_reg;
    assign o_clock_mode            = clk_mode_reg;
    assign o_ref_sel               = ref_sel_reg;
    assign o_fifo_clear            = fifo_clr_reg;
    assign o_slow_mode             = slow_reg;
    assign o_bias_force            = fbg_reg;
    assign o_wake_delay_bypass     = wake_byp_reg;
    assign o_dac_word_valid        = dac_valid_reg;
    assign o_dac_ctrl              = dac_ctrl_reg;
    assign o_dac_data              = dac_data_reg;
    assign o_dac_hiz               = dac_hiz_reg;
endmodule
`default_nettype wire

/* logic/acd_host.sv */
// host end: frames software-given bits MSB first and collects returned bits
`timescale 1ns/1ns
`default_nettype none
module acd_host
    import acd_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_resetn,
    acd_link_if.host         link,
    input  wire logic [1:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata
);
    typedef enum logic [2:0] {
        HS_IDLE  = 3'b000,
        HS_LEAD  = 3'b001,
        HS_HIGH  = 3'b010,
        HS_LOW   = 3'b011,
        HS_TRAIL = 3'b100,
        HS_GAP   = 3'b101
    } acd_host_state_t;

    localparam logic [3:0] HALF_LAST = 4'(HOST_HALF_CYC - 1);

    acd_host_state_t state_reg;
    logic [23:0]     tx_reg, sr_reg, rx_reg;
    logic [4:0]      nbits_reg, left_reg;
    logic [3:0]      tim_reg;
    logic            cs_n_reg, sclk_reg, din_reg;
    logic            s1_reg, s2_reg, s3_reg, dout_f_reg;
    logic [31:0]     rdata_reg;
    logic            start, tick;

    always_comb begin
        start = i_wr && (i_addr == HOST_REG_CTRL) && (state_reg == HS_IDLE)
                && (i_wdata[4:0] != 5'h00) && (i_wdata[4:0] <= HOST_MAX_BITS);
        tick  = (tim_reg == HALF_LAST);
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s1_reg     <= 1'b0;
            s2_reg     <= 1'b0;
            s3_reg     <= 1'b0;
            dout_f_reg <= 1'b0;
        end else begin
            s1_reg <= link.dout;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                dout_f_reg <= s3_reg;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tx_reg    <= 24'h000000;
            nbits_reg <= 5'h00;
            rdata_reg <= 32'h00000000;
        end else begin
            if (i_wr && i_addr == HOST_REG_DATA) begin
                tx_reg <= i_wdata[23:0];
            end else if (start) begin
                nbits_reg <= i_wdata[4:0];
            end
            if (!i_rd) begin
                rdata_reg <= 32'h00000000;
            end else if (i_addr == HOST_REG_DATA) begin
                rdata_reg <= {8'h00, tx_reg};
            end else if (i_addr == HOST_REG_CTRL) begin
                rdata_reg <= {27'h0, nbits_reg};
            end else if (i_addr == HOST_REG_STAT) begin
                rdata_reg <= {31'h0, state_reg != HS_IDLE};
            end else begin
                rdata_reg <= {8'h00, rx_reg};
            end
        end
    end

    // a frame always runs to its programmed length; the device decides meaning
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= HS_IDLE;
            tim_reg   <= 4'h0;
            sr_reg    <= 24'h000000;
            rx_reg    <= 24'h000000;
            left_reg  <= 5'h00;
            cs_n_reg  <= 1'b1;
            sclk_reg  <= 1'b0;
            din_reg   <= 1'b0;
        end else begin
            tim_reg <= (state_reg == HS_IDLE || tick) ? 4'h0 : tim_reg + 4'h1;
            case (state_reg)
                HS_IDLE: begin
                    if (start) begin
                        sr_reg    <= tx_reg << (HOST_MAX_BITS - i_wdata[4:0]);
                        din_reg   <= tx_reg[5'(i_wdata[4:0] - 5'h01)];
                        left_reg  <= i_wdata[4:0];
                        rx_reg    <= 24'h000000;
                        cs_n_reg  <= 1'b0;
                        state_reg <= HS_LEAD;
                    end
                end
                HS_LEAD: begin
                    if (tick) begin
                        sclk_reg  <= 1'b1;
                        state_reg <= HS_HIGH;
                    end
                end
                HS_HIGH: begin
                    if (tick) begin
                        rx_reg    <= {rx_reg[22:0], dout_f_reg};
                        sclk_reg  <= 1'b0;
                        left_reg  <= left_reg - 5'h01;
                        state_reg <= HS_LOW;
                    end
                end
                HS_LOW: begin
                    if (tick && left_reg == 5'h00) begin
                        state_reg <= HS_TRAIL;
                    end else if (tick) begin
                        sr_reg    <= {sr_reg[22:0], 1'b0};
                        din_reg   <= sr_reg[22];
                        sclk_reg  <= 1'b1;
                        state_reg <= HS_HIGH;
                    end
                end
                HS_TRAIL: begin
                    if (tick) begin
                        cs_n_reg  <= 1'b1;
                        din_reg   <= 1'b0;
                        state_reg <= HS_GAP;
                    end
                end
                default: begin
                    if (tick) begin
                        state_reg <= HS_IDLE;
                    end
                end
            endcase
        end
    end

    assign link.cs_n = cs_n_reg;
    assign link.sclk = sclk_reg;
    assign link.din  = din_reg;
    assign o_rdata   = rdata_reg;
endmodule
`default_nettype wire

/* bench/acd_link_asserts.sv */
// link timing and idle-level assertions
`timescale 1ns/1ns
`default_nettype none
module acd_link_asserts (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_din,
    input wire logic i_dout
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    // both half periods span eight system cycles
    sequence s_low_half; !i_sclk[*8] ##1 i_sclk; endsequence
    sequence s_high_half; i_sclk[*8] ##1 !i_sclk; endsequence
    a_idle_clk_low: assert property (i_cs_n |-> !i_sclk)
        else $error("idle clock");
    a_lead_low: assert property ($fell(i_cs_n) |-> s_low_half)
        else $error("lead time");
    a_high_half: assert property ($rose(i_sclk) |-> s_high_half)
        else $error("high phase");
    a_low_half: assert property ($fell(i_sclk) |-> !i_sclk[*8])
        else $error("low phase");
    a_din_held: assert property ($rose(i_sclk) |=> $stable(i_din)[*8])
        else $error("din moved");
    a_dout_held: assert property ($rose(i_sclk) |=> $stable(i_dout)[*8])
        else $error("dout moved");
    a_dout_idle: assert property (i_cs_n[*8] |-> !i_dout)
        else $error("dout idle");
    a_select_dout: assert property ($fell(i_cs_n) |-> !i_dout)
        else $error("dout at select");
endmodule
`default_nettype wire

/* bench/adc_dac_serial_command_decoder_bench.sv */
// bench for both link ends
`timescale 1ns/1ns
`default_nettype none
module adc_dac_serial_command_decoder_bench;
    logic        i_sys_clk = 1'b0, i_resetn = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [1:0]  addr = 2'h0, cm, rs, sm;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic [3:0]  oe, go, hz, dc;
    logic [5:0]  ac;
    logic [4:0]  sr;
    logic [11:0] dd;
    logic        aa, rp, fc, sl, bf, wb, dv;
    int          miscompares = 0, n_tests = 0, n_clr = 0, n_dv = 0;
    acd_link_if link ();
    acd_host acd_host_i (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .link(link),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata));
    acd_device acd_device_i (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .link(link),
        .i_gpio_in(4'ha), .o_gpio_out(go), .o_gpio_oe(oe), .o_avg_active(aa),
        .o_avg_conversions(ac), .o_single_channel_repeat(rp), .o_scan_results(sr),
        .o_scan_mode(sm), .o_clock_mode(cm), .o_ref_sel(rs), .o_fifo_clear(fc),
        .o_slow_mode(sl), .o_bias_force(bf), .o_wake_delay_bypass(wb),
        .o_dac_word_valid(dv), .o_dac_ctrl(dc), .o_dac_data(dd), .o_dac_hiz(hz));
    acd_link_asserts acd_link_asserts_i (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
        .i_cs_n(link.cs_n), .i_sclk(link.sclk), .i_din(link.din), .i_dout(link.dout));
    always #50 i_sys_clk = ~i_sys_clk;
    // one-cycle pulses, counted in passing
    always @(posedge i_sys_clk) n_clr += (fc === 1'b1);
    always @(posedge i_sys_clk) n_dv += (dv === 1'b1);
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [1:0] a, input logic [23:0] d);
        @(posedge i_sys_clk);
        addr <= a;
        wdata <= {8'h00, d};
        {wr, rd} <= {w, !w};
        @(posedge i_sys_clk);
        {wr, rd} <= 2'b00;
        #1 q = rdata;
    endtask
    // busy is polled so a frame has ended before the next starts
    task automatic frame(input logic [4:0] n, input logic [23:0] d);
        bus(1'b1, 2'h0, d);
        bus(1'b1, 2'h1, {19'h0, n});
        q = 32'h1;
        for (int k = 0; k < 900 && q[0] !== 1'b0; k++) bus(1'b0, 2'h2, 24'h0);
        bus(1'b0, 2'h3, 24'h0);
    endtask
    task automatic t_gpio;
        chk("reset", {2'h2, 2'h2, 1'b0, 4'h0}, {cm, rs, aa, oe});
        frame(5'd16, 24'h0003c0);
        chk("cfg", {16'h0, 8'hcc}, {q[15:0], oe, go});
        frame(5'd16, 24'h000250);
        chk("write", 8'he4, {oe, go});
        frame(5'd12, 24'h00002f);
        chk("cut", 8'he4, {oe, go});
        frame(5'd16, 24'h000100);
        chk("read", 32'ha, q);
    endtask
    task automatic t_adc;
        frame(5'd24, 24'h7c3b84);
        chk("no avg", {1'b0, 1'b1, 5'h10, 2'h2}, {aa, rp, sr, sm});
        frame(5'd8, 24'h00005c);
        chk("avg", 7'h50, {aa, ac});
        frame(5'd8, 24'h00000b);
        chk("slow", 4'hf, {sl, bf, wb, aa});
        frame(5'd16, 24'h000100);
        chk("slow read", 32'ha, q);
        frame(5'd8, 24'h00000c);
        chk("full", {2'h2, 1'b0, 4'he, 2'h0}, {cm, aa, oe, sm});
        chk("clears", 32'h2, n_clr);
    endtask
    task automatic t_dac;
        frame(5'd24, 24'h1af034);
        chk("dac", {4'h3, 4'hf, 12'h034}, {hz, dc, dd});
        // select in one frame, word in the next
        frame(5'd8, 24'h000010);
        frame(5'd16, 24'h00f012);
        chk("power up", {4'h2, 4'hf, 12'h012}, {hz, dc, dd});
        chk("words", 32'h2, n_dv);
    endtask
    task automatic tally_and_finish;
        $display("tests %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        t_gpio();
        t_adc();
        t_dac();
        tally_and_finish();
    end
    initial begin
        #5_000_000;
        miscompares++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
